// *** rtl/ccsp_pkg.sv ***
// Functional notes
// [R1] Every control byte, address or data, arrives least significant bit first.
// [R2] Address phase: phase line low while eight clock pulses carry eight bits.
// [R3] Address bits 1:0 pick set: 00 volume/emphasis/mute/power, 10 clock/format/filter.
// [R4] Address bits 7:2 are device address; mismatch deselects and ignores data bytes.
// [R5] Selection and chosen set persist for all data bytes until next address.
// [R6] Link is write-only; the device never drives data and offers no readback.
// [R7] Host keeps clock and data rate at most 128 times the sample rate.
// [R8] A data byte commits only after its eighth bit; partial bytes change nothing. Here only a phase line change drops a partial byte.
// [R9] Data bits 7:6 pick the register, bits 5:0 carry its value.
// [R10] Status set, bits 7:6 = 00: ratio 5:4, format 3:1, filter enable 0.
// [R11] Clock ratio: 00 512fs, 01 384fs, 10 256fs, 11 unused.
// [R12] Format: 000 I2S, 001-011 LSB 16/18/20, 100 MSB, 101-111 mixed.
// [R13] Filter enable 1 turns DC removal on; 0 turns it off.
// [R14] Data set, bits 7:6 = 00: load six-bit volume attenuation from 5:0.
// [R15] Volume for both channels: 0,1 give 0 dB, 1 dB steps, coarse, all-ones mute.
// [R16] Data set, bits 7:6 = 10: emphasis from 4:3, mute from bit 2.
// [R17] Emphasis: 00 none, 01 32 kHz, 10 44.1 kHz, 11 48 kHz.
// [R18] Mute bit 1 silences the playback path; 0 leaves it playing.
// [R19] Data set, bits 7:6 = 11: bit 1 ADC power on, bit 0 DAC on.
// [R20] No power-up reset exists, so the host writes every register first; here rst_n loads CFG_RST into cfg.
// [R21] DAC power change runs a cosine fade lasting 128 audio samples.
// [R22] Data phase holds the phase line high; bits sampled on rising clock.
package ccsp_pkg;

  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] SEL_STATUS_CFG = 2'h0;
  localparam logic [1:0] SEL_VOLUME = 2'h0;
  localparam logic [1:0] SEL_EMPHASIS = 2'h2;
  localparam logic [1:0] SEL_POWER = 2'h3;
  localparam logic [5:0] VOL_UNITY_MAX = 6'h01;
  localparam logic [5:0] VOL_FINE_MAX = 6'h33;
  localparam logic [5:0] VOL_COARSE_MAX = 6'h38;
  localparam logic [5:0] VOL_MUTE_CODE = 6'h3F;
  localparam logic [7:0] VOL_DB_MUTE = 8'hFF;
  localparam int FADE_SAMPLES = 128;
  localparam logic [6:0] FADE_LAST = 7'(FADE_SAMPLES - 1);

  typedef enum logic [1:0] {
    SET_DATA = 2'b00,
    SET_UNUSED_A = 2'b01,
    SET_STATUS = 2'b10,
    SET_UNUSED_B = 2'b11
  } ccsp_set_t;

  typedef struct packed {
    logic addr_phase;
    logic [7:0] data;
  } ccsp_byte_t;

  typedef struct packed {
    logic [1:0] clock_ratio;
    logic [2:0] data_format;
    logic offset_removal_en;
    logic [5:0] vol_atten;
    logic [1:0] emphasis_sel;
    logic dac_silence_bit;
    logic adc_power_on;
    logic dac_power_on;
  } ccsp_cfg_t;

  localparam ccsp_cfg_t CFG_RST = '0;
  localparam ccsp_byte_t BYTE_RST = '0;

endpackage

// *** rtl/ccsp_top.sv ***
`timescale 1ns/1ps
module ccsp_top
  import ccsp_pkg::*;
#(
  // Arbitrary neutral device address.
  parameter logic [5:0] DEV_ADDR = 6'h2A
)
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control link from the host
  input wire logic ctl_serial_clock,
  input wire logic ctl_phase_line,
  input wire logic ctl_serial_data,
  // Audio sample strobe on the core clock
  input wire logic sample_tick,
  // Control settings
  output ccsp_cfg_t cfg,
  output logic [7:0] vol_db,
  output logic vol_full_mute,
  // DAC power fade
  output logic fade_active,
  output logic fade_rising,
  output logic [6:0] fade_step
);

  // ----------------------------------------------------------
  // Volume code to attenuation in dB
  // ----------------------------------------------------------

  function automatic logic [7:0] vol_to_db(input logic [5:0] code);
    logic [7:0] db;
    db = 8'h00;
    if (code <= VOL_UNITY_MAX)
    begin
      db = 8'h00;
    end
    else if (code <= VOL_FINE_MAX)
    begin
      db = {2'h0, code} - 8'h01;
    end
    else if (code == VOL_MUTE_CODE)
    begin
      db = VOL_DB_MUTE;
    end
    else
    begin
      unique case (code)
        6'h34: db = 8'h34;
        6'h35: db = 8'h36;
        6'h36: db = 8'h39;
        6'h37: db = 8'h3C;
        6'h38: db = 8'h42;
        default: db = 8'h42 + 8'({2'h0, code} - {2'h0, VOL_COARSE_MAX}) * 8'h03;
      endcase
    end
    return db;
  endfunction

  // ----------------------------------------------------------
  // Link domain reset
  // ----------------------------------------------------------

  // The link clock only runs inside frames, so reset reaches
  // this side only while the host is clocking.
  logic [1:0] lrst_q;
  logic link_rst_n;

  always_ff @(posedge ctl_serial_clock)
  begin
    lrst_q <= {lrst_q[0], rst_n};
  end

  assign link_rst_n = lrst_q[1];

  // ----------------------------------------------------------
  // Link domain bit counter
  // ----------------------------------------------------------

  logic [2:0] lcnt;
  logic lmode_prev;
  logic phase_start;
  logic byte_done;

  // A change of the phase line starts a new byte at bit one,
  // which also throws away any partial byte.
  assign phase_start = ctl_phase_line != lmode_prev;
  assign byte_done = !phase_start && lcnt == BIT_LAST; // [R8]

  always_ff @(posedge ctl_serial_clock)
  begin
    if (!link_rst_n)
    begin
      lcnt <= 3'h0;
      lmode_prev <= 1'b1;
    end
    else if (phase_start)
    begin
      lcnt <= 3'h1; // [R2]
      lmode_prev <= ctl_phase_line; // [R22]
    end
    else
    begin
      lcnt <= lcnt + 3'h1;
    end
  end

  // ----------------------------------------------------------
  // Link domain shifter and byte hand-off
  // ----------------------------------------------------------

  // The data line is an input only; nothing here can drive it.
  logic [7:0] lshift;
  ccsp_byte_t lword;
  logic ltoggle;

  // Bits enter at the top, so the first bit ends at bit 0.
  always_ff @(posedge ctl_serial_clock)
  begin
    lshift <= {ctl_serial_data, lshift[7:1]}; // [R1] [R6] [R22]
  end

  always_ff @(posedge ctl_serial_clock)
  begin
    if (!link_rst_n)
    begin
      lword <= BYTE_RST;
      ltoggle <= 1'b0;
    end
    else if (byte_done)
    begin
      lword.addr_phase <= !ctl_phase_line; // [R2]
      lword.data <= {ctl_serial_data, lshift[7:1]}; // [R1]
      ltoggle <= ~ltoggle;
    end
  end

  lsb_first_a: assert property (@(posedge ctl_serial_clock) disable iff (!link_rst_n) // [R1] [R2]
    phase_start ##1 !phase_start [*7] |=>
      ltoggle != $past(ltoggle) && lword.data[0] == $past(ctl_serial_data, 8))
    else $error("byte not delivered after eight bits, lsb first");

  // ----------------------------------------------------------
  // Crossing into the core domain
  // ----------------------------------------------------------

  // The word stays still for a whole byte time, far longer
  // than the toggle takes to cross, so it is read directly.
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic tog_seen;
  logic evt;
  ccsp_byte_t rx;

  always_ff @(posedge core_clk)
  begin
    tog_s1 <= ltoggle;
    tog_s2 <= tog_s1;
    tog_s3 <= tog_s2;
  end

  assign evt = tog_s2 == tog_s3 && tog_s3 != tog_seen;
  assign rx = lword;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tog_seen <= 1'b0;
    end
    else if (evt)
    begin
      tog_seen <= tog_s3;
    end
  end

  // ----------------------------------------------------------
  // Address phase
  // ----------------------------------------------------------

  logic selected;
  ccsp_set_t set_sel;
  logic addr_evt;
  logic wr;
  logic status_wr;
  logic vol_wr;
  logic emph_wr;
  logic pwr_wr;

  assign addr_evt = evt && rx.addr_phase;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      selected <= 1'b0;
      set_sel <= SET_UNUSED_A;
    end
    else if (addr_evt)
    begin
      selected <= rx.data[7:2] == DEV_ADDR; // [R4]
      set_sel <= ccsp_set_t'(rx.data[1:0]); // [R3]
    end
  end

  addr_match_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
    addr_evt |=> selected == ($past(rx.data[7:2]) == DEV_ADDR))
    else $error("selection does not follow the address match");

  set_pick_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
    addr_evt |=> set_sel == ccsp_set_t'($past(rx.data[1:0])))
    else $error("register set not taken from address bits 1:0");

  sel_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
    !addr_evt ##1 !addr_evt |=> $stable(selected) && $stable(set_sel))
    else $error("selection changed without an address phase");

  // ----------------------------------------------------------
  // Data phase decode
  // ----------------------------------------------------------

  // Unused sets and the unused register code fall through
  // without effect.
  assign wr = evt && !rx.addr_phase && selected; // [R4] [R5] [R8]
  assign status_wr = wr && set_sel == SET_STATUS && rx.data[7:6] == SEL_STATUS_CFG; // [R9]
  assign vol_wr = wr && set_sel == SET_DATA && rx.data[7:6] == SEL_VOLUME; // [R9]
  assign emph_wr = wr && set_sel == SET_DATA && rx.data[7:6] == SEL_EMPHASIS; // [R9]
  assign pwr_wr = wr && set_sel == SET_DATA && rx.data[7:6] == SEL_POWER; // [R9]

  // ----------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------

  // The real part powers up undefined; a known value after
  // reset is kept here, and software still writes all of them.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfg.clock_ratio <= CFG_RST.clock_ratio; // [R20]
      cfg.data_format <= CFG_RST.data_format;
      cfg.offset_removal_en <= CFG_RST.offset_removal_en;
    end
    else if (status_wr)
    begin
      cfg.clock_ratio <= rx.data[5:4]; // [R10] [R11]
      cfg.data_format <= rx.data[3:1]; // [R10] [R12]
      cfg.offset_removal_en <= rx.data[0]; // [R10] [R13]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfg.vol_atten <= CFG_RST.vol_atten;
    end
    else if (vol_wr)
    begin
      cfg.vol_atten <= rx.data[5:0]; // [R14]
    end
  end

  // Bits 5, 1 and 0 of this byte carry nothing and are dropped.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfg.emphasis_sel <= CFG_RST.emphasis_sel;
      cfg.dac_silence_bit <= CFG_RST.dac_silence_bit;
    end
    else if (emph_wr)
    begin
      cfg.emphasis_sel <= rx.data[4:3]; // [R16] [R17]
      cfg.dac_silence_bit <= rx.data[2]; // [R16] [R18]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cfg.adc_power_on <= CFG_RST.adc_power_on;
      cfg.dac_power_on <= CFG_RST.dac_power_on;
    end
    else if (pwr_wr)
    begin
      cfg.adc_power_on <= rx.data[1]; // [R19]
      cfg.dac_power_on <= rx.data[0]; // [R19]
    end
  end

  status_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
    status_wr |=> cfg.clock_ratio == $past(rx.data[5:4])
      && cfg.data_format == $past(rx.data[3:1])
      && cfg.offset_removal_en == $past(rx.data[0]))
    else $error("status byte not loaded into its fields");

  vol_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
    vol_wr |=> cfg.vol_atten == $past(rx.data[5:0]) && $stable(cfg.emphasis_sel))
    else $error("volume byte not loaded");

  emph_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
    emph_wr |=> cfg.emphasis_sel == $past(rx.data[4:3])
      && cfg.dac_silence_bit == $past(rx.data[2]) && $stable(cfg.vol_atten))
    else $error("emphasis and mute byte not loaded");

  power_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R19]
    pwr_wr |=> {cfg.adc_power_on, cfg.dac_power_on} == $past(rx.data[1:0]))
    else $error("power byte not loaded");

  no_stray_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R8]
    !wr ##1 !wr |=> $stable(cfg))
    else $error("settings changed without a committed data byte");

  // ----------------------------------------------------------
  // Volume decode
  // ----------------------------------------------------------

  // One code serves both channels.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      vol_db <= 8'h00;
      vol_full_mute <= 1'b0;
    end
    else
    begin
      vol_db <= vol_to_db(cfg.vol_atten); // [R15]
      vol_full_mute <= cfg.vol_atten == VOL_MUTE_CODE; // [R15]
    end
  end

  vol_map_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
    cfg.vol_atten == VOL_FINE_MAX ##1 $stable(cfg.vol_atten) |-> vol_db == 8'h32 && !vol_full_mute)
    else $error("volume code 110011 not decoded to 50 dB");

  // ----------------------------------------------------------
  // DAC power fade
  // ----------------------------------------------------------

  // A power change in mid-fade restarts the fade in the new
  // direction, with fade_step starting again from 0.
  logic dac_pwr_q;
  logic fade_start;

  assign fade_start = cfg.dac_power_on != dac_pwr_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dac_pwr_q <= CFG_RST.dac_power_on;
    end
    else
    begin
      dac_pwr_q <= cfg.dac_power_on;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fade_active <= 1'b0;
      fade_rising <= 1'b0;
      fade_step <= 7'h00;
    end
    else if (fade_start)
    begin
      fade_active <= 1'b1; // [R21]
      fade_rising <= cfg.dac_power_on;
      fade_step <= 7'h00;
    end
    else if (fade_active && sample_tick)
    begin
      if (fade_step == FADE_LAST)
      begin
        fade_active <= 1'b0; // [R21]
      end
      else
      begin
        fade_step <= fade_step + 7'h01;
      end
    end
  end

  fade_begin_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R21]
    fade_start |=> fade_active && fade_step == 7'h00 && fade_rising == $past(cfg.dac_power_on))
    else $error("fade did not start on a DAC power change");

  fade_end_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R21]
    fade_active && sample_tick && fade_step == FADE_LAST && !fade_start |=> !fade_active)
    else $error("fade did not end after 128 samples");

endmodule // ccsp_top

// *** tb/ccsp_host.sv ***
`timescale 1ns/1ps
module ccsp_host
(
  // Control link toward the device
  output logic sclk,
  output logic phase,
  output logic sdat
);
  initial
  begin
    sclk = 1'b1;
    phase = 1'b1;
    sdat = 1'b0;
  end

  // Sends the first n bits of a byte; the clock stands high between frames.
  task automatic send(input logic ph, input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      #40 sclk = 1'b0;
      phase = ph;
      sdat = b[i];
      #40 sclk = 1'b1;
    end
    #40 sdat = ~sdat;
  endtask
endmodule // ccsp_host

// *** tb/ccsp_top_test.sv ***
`timescale 1ns/1ps
module ccsp_top_test;
  import ccsp_pkg::*;
  // Arbitrary device address for this bench.
  localparam logic [5:0] ADDR = 6'h2A;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_tick = 1'b0;
  logic link_clk;
  logic link_phase;
  logic link_data;
  ccsp_cfg_t cfg;
  logic [7:0] vol_db;
  logic vol_full_mute;
  logic fade_active;
  logic fade_rising;
  logic [6:0] fade_step;
  ccsp_cfg_t exp = CFG_RST;
  logic sel = 1'b0;
  logic [1:0] set = 2'h0;
  int failures = 0;
  int compares = 0;

  ccsp_host i_ccsp_host (.sclk(link_clk), .phase(link_phase), .sdat(link_data));

  ccsp_top #(.DEV_ADDR(ADDR)) i_ccsp_top (
    .core_clk(core_clk), .rst_n(rst_n), .ctl_serial_clock(link_clk), .ctl_phase_line(link_phase),
    .ctl_serial_data(link_data), .sample_tick(sample_tick), .cfg(cfg), .vol_db(vol_db),
    .vol_full_mute(vol_full_mute), .fade_active(fade_active), .fade_rising(fade_rising),
    .fade_step(fade_step)
  );

  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic void apply(input logic ph, input logic [7:0] b);
    if (!ph)
    begin
      sel = (b[7:2] == ADDR);
      set = b[1:0];
    end
    else if (sel && set == 2'b10 && b[7:6] == 2'b00)
      {exp.clock_ratio, exp.data_format, exp.offset_removal_en} = b[5:0];
    else if (sel && set == 2'b00)
      case (b[7:6])
        2'b00: exp.vol_atten = b[5:0];
        2'b10: {exp.emphasis_sel, exp.dac_silence_bit} = b[4:2];
        2'b11: {exp.adc_power_on, exp.dac_power_on} = b[1:0];
        default: ;
      endcase
  endfunction

  function automatic logic [7:0] db(input logic [5:0] c);
    if (c == 6'h3F)
      return 8'hFF;
    if (c <= 6'h01)
      return 8'h00;
    if (c <= 6'h33)
      return {2'h0, c} - 8'h01;
    if (c >= 6'h38)
      return 8'h42 + 8'(3 * (c - 6'h38));
    case (c)
      6'h34: return 8'h34;
      6'h35: return 8'h36;
      6'h36: return 8'h39;
      default: return 8'h3C;
    endcase
  endfunction

  task automatic xfer(input logic ph, input logic [7:0] b);
    // A random start keeps the link clock out of step with the core clock.
    #($urandom_range(1, 19));
    i_ccsp_host.send(ph, b, 8);
    apply(ph, b);
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    check("cfg", cfg, exp);
    check("vol_db", vol_db, db(exp.vol_atten));
    check("vol_full_mute", vol_full_mute, exp.vol_atten == 6'h3F);
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk) sample_tick <= 1'b1;
      @(posedge core_clk) sample_tick <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  initial
  begin
    // Some 240 frames of under a microsecond each and 256 sample ticks need about 230 us.
    #450000;
    failures++;
    end_of_test();
  end

  initial
  begin
    logic [5:0] vols [12];
    logic [31:0] r;
    logic ph;
    vols = '{6'h00, 6'h01, 6'h02, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39, 6'h3E, 6'h3F};
    void'($urandom(96));
    fork
      i_ccsp_host.send(1'b1, 8'h00, 3);
      repeat (16) @(posedge core_clk);
    join
    rst_n <= 1'b1;
    // The link side leaves reset two of its own clock edges after rst_n rises,
    // so two idle clocks go by before the first frame.
    i_ccsp_host.send(1'b1, 8'h00, 2);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check("cfg", cfg, CFG_RST);
    check("fade_active", fade_active, 1'b0);
    $display("test reset done");
    xfer(1'b0, {ADDR, 2'b10});
    for (int i = 0; i < 8; i++)
      xfer(1'b1, {2'b00, i[1:0], i[2:0], i[0]});
    $display("test status done");
    xfer(1'b0, {ADDR, 2'b00});
    foreach (vols[i])
      xfer(1'b1, {2'b00, vols[i]});
    for (int i = 0; i < 4; i++)
      xfer(1'b1, {3'b101, i[1:0], i[0], 2'b11});
    xfer(1'b1, 8'h55);
    $display("test data done");
    xfer(1'b0, {ADDR ^ 6'h01, 2'b00});
    xfer(1'b1, 8'h3F);
    xfer(1'b0, {ADDR, 2'b01});
    xfer(1'b1, 8'h05);
    xfer(1'b0, {ADDR, 2'b11});
    xfer(1'b1, 8'h07);
    xfer(1'b0, {ADDR, 2'b00});
    i_ccsp_host.send(1'b1, 8'hC1, 7);
    xfer(1'b0, {ADDR, 2'b00});
    check("fade_active", fade_active, 1'b0);
    $display("test refusal done");
    xfer(1'b1, 8'hFF);
    check("fade_active", fade_active, 1'b1);
    check("fade_rising", fade_rising, 1'b1);
    check("fade_step", fade_step, 7'h00);
    tick(127);
    check("fade_step", fade_step, 7'h7F);
    check("fade_active", fade_active, 1'b1);
    tick(1);
    check("fade_active", fade_active, 1'b0);
    xfer(1'b1, 8'hC2);
    check("fade_rising", fade_rising, 1'b0);
    check("fade_active", fade_active, 1'b1);
    tick(128);
    check("fade_active", fade_active, 1'b0);
    $display("test fade done");
    for (int i = 0; i < 200; i++)
    begin
      r = $urandom;
      ph = (r[9:8] != 2'b00);
      xfer(ph, (ph || r[10]) ? r[7:0] : {ADDR, r[1:0]});
    end
    $display("test random done");
    end_of_test();
  end
endmodule // ccsp_top_test
